/* verilog/ddc_sel_pkg.sv */
// constants for the downconverter mixer input and nco profile selection block
// assumes a classic wishbone slave with 32-bit data and byte addresses
// Behaviour
// - in mode 0 the active profile is the four-bit register channel select field.
// - in mode 1 the profile is two zero bits, then pin b low, then pin a low.
// - in mode 2 the profile is two zero bits, then pin b high, then pin a high.
// - in mode 3 the profile is two zero bits, then pin a high, then pin a low.
// - in mode 4 the profile is two zero bits, then pin b high, then pin b low.
// - in mode 5 the profile is pin b high, pin a high, pin b low, pin a low.
// - in mode 6 the profile is pin b high, pin b low, pin a high, pin a low.
// - in mode 8 the internal counter steps on each rising edge of pin a low.
// - in mode 9 the internal counter steps on each rising edge of pin a high.
// - in mode 10 the internal counter steps on each rising edge of pin b low.
// - in mode 11 the internal counter steps on each rising edge of pin b high.
// - in the edge modes the counter wraps to zero once it has reached the channel select field.
// - the channel select field is the profile number in plain binary.
// - mode and channel select fields reset to zero and are read and write.
// - the channel select field reaches profile 15.
package ddc_sel_pkg;
	localparam int          ADR_W          = 12;
	localparam int          IDX_W          = 10;
	// register indices; byte address is four times the index
	localparam logic [9:0]  MIXER_SEL_IDX  = 10'h371;
	localparam logic [9:0]  NCO_CTRL_IDX   = 10'h374;
	localparam logic [9:0]  PROFILE_IDX    = 10'h3F0;
	localparam int          I_SEL_BIT      = 0;
	localparam int          Q_SEL_BIT      = 2;
	localparam logic        I_SEL_RESET    = 1'h1;
	localparam logic        Q_SEL_RESET    = 1'h1;
	localparam int          CHAN_LSB       = 0;
	localparam int          MODE_LSB       = 4;
	localparam logic [3:0]  CHAN_RESET     = 4'h0;
	localparam logic [3:0]  MODE_RESET     = 4'h0;
	// pin vector order
	localparam int          PIN_A_LOW      = 0;
	localparam int          PIN_A_HIGH     = 1;
	localparam int          PIN_B_LOW      = 2;
	localparam int          PIN_B_HIGH     = 3;

	typedef enum logic [3:0]
	{
		MODE_REG      = 4'h0,
		MODE_B0_A0    = 4'h1,
		MODE_B1_A1    = 4'h2,
		MODE_A1_A0    = 4'h3,
		MODE_B1_B0    = 4'h4,
		MODE_INTERLV  = 4'h5,
		MODE_GROUPED  = 4'h6,
		MODE_EDGE_A0  = 4'h8,
		MODE_EDGE_A1  = 4'h9,
		MODE_EDGE_B0  = 4'hA,
		MODE_EDGE_B1  = 4'hB
	} sel_mode_t;
endpackage

/* verilog/ddc_nco_channel_select.sv */
// mixer input routing and nco profile selection for the third downconverter
// assumes a wishbone master on clock and asynchronous profile pins from outside logic
//
// The Wishbone register port was decided locally.
`timescale 1ns/1ps
module ddc_nco_channel_select
(
	input  wire logic        clock,
	input  wire logic        rst,
	input  wire logic        wb_cyc,
	input  wire logic        wb_stb,
	input  wire logic        wb_we,
	input  wire logic [11:0] wb_adr,
	input  wire logic [3:0]  wb_sel,
	input  wire logic [31:0] wb_dat_w,
	output logic      [31:0] wb_dat_r,
	output logic             wb_ack,
	input  wire logic        profile_pin_a_low,
	input  wire logic        profile_pin_a_high,
	input  wire logic        profile_pin_b_low,
	input  wire logic        profile_pin_b_high,
	output logic             i_from_b,
	output logic             q_from_b,
	output logic      [3:0]  active_profile
);

	logic             ack_r;
	logic [31:0]      rdata_r;
	logic             i_sel_r;
	logic             q_sel_r;
	logic [3:0]       mode_r;
	logic [3:0]       chan_r;
	logic [3:0]       pin_s1_r;
	logic [3:0]       pin_s2_r;
	logic [3:0]       pin_s3_r;
	logic [3:0]       lvl_r;
	logic [3:0]       lvl_nxt;
	logic [3:0]       rise;
	logic [3:0]       cnt_r;
	logic [3:0]       cnt_nxt;
	logic [3:0]       profile_r;
	logic [3:0]       profile_nxt;
	logic             i_out_r;
	logic             q_out_r;
	logic [9:0]       idx;
	logic             req;
	logic             wr_commit;
	logic [31:0]      rd_mux;

	function automatic logic is_edge_mode(input logic [3:0] m);
		is_edge_mode = (m[3:2] == 2'b10);
	endfunction

	default clocking cb @(posedge clock); endclocking
	default disable iff (rst);

	assign idx       = wb_adr[11:2];
	assign req       = wb_cyc & wb_stb;
	// write lands on the edge at which the master sees ack
	assign wr_commit = req & wb_we & ack_r & wb_sel[0];
	assign wb_ack    = ack_r;
	assign wb_dat_r  = rdata_r;

	always_ff @(posedge clock)
	begin
		if (rst)
			ack_r <= 1'b0;
		else
			ack_r <= req & ~ack_r;
	end

	always_comb
	begin
		rd_mux = 32'h0000_0000;
		case (idx)
			ddc_sel_pkg::MIXER_SEL_IDX:
			begin
				rd_mux[ddc_sel_pkg::I_SEL_BIT] = i_sel_r;
				rd_mux[ddc_sel_pkg::Q_SEL_BIT] = q_sel_r;
			end
			ddc_sel_pkg::NCO_CTRL_IDX:
				rd_mux[7:0] = {mode_r, chan_r};
			ddc_sel_pkg::PROFILE_IDX:
				rd_mux[7:0] = {cnt_r, profile_r};
			default:
				rd_mux = 32'h0000_0000;
		endcase
	end

	always_ff @(posedge clock)
	begin
		if (rst)
			rdata_r <= 32'h0000_0000;
		else if (req & ~ack_r & ~wb_we)
			rdata_r <= rd_mux;
	end

	always_ff @(posedge clock)
	begin
		if (rst)
		begin
			i_sel_r <= ddc_sel_pkg::I_SEL_RESET;
			q_sel_r <= ddc_sel_pkg::Q_SEL_RESET;
		end
		else if (wr_commit && idx == ddc_sel_pkg::MIXER_SEL_IDX)
		begin
			i_sel_r <= wb_dat_w[ddc_sel_pkg::I_SEL_BIT];
			q_sel_r <= wb_dat_w[ddc_sel_pkg::Q_SEL_BIT];
		end
	end

	always_ff @(posedge clock)
	begin
		if (rst)
		begin
			mode_r <= ddc_sel_pkg::MODE_RESET;
			chan_r <= ddc_sel_pkg::CHAN_RESET;
		end
		else if (wr_commit && idx == ddc_sel_pkg::NCO_CTRL_IDX)
		begin
			mode_r <= wb_dat_w[ddc_sel_pkg::MODE_LSB +: 4];
			chan_r <= wb_dat_w[ddc_sel_pkg::CHAN_LSB +: 4];
		end
	end

	// 1 selects channel B
	always_ff @(posedge clock)
	begin
		if (rst)
		begin
			i_out_r <= ddc_sel_pkg::I_SEL_RESET;
			q_out_r <= ddc_sel_pkg::Q_SEL_RESET;
		end
		else
		begin
			i_out_r <= i_sel_r;
			q_out_r <= q_sel_r;
		end
	end

	assign i_from_b = i_out_r;
	assign q_from_b = q_out_r;

	// three-stage synchroniser; a level counts once stages two and three agree
	always_ff @(posedge clock)
	begin
		if (rst)
		begin
			pin_s1_r <= 4'h0;
			pin_s2_r <= 4'h0;
			pin_s3_r <= 4'h0;
		end
		else
		begin
			pin_s1_r <= {profile_pin_b_high, profile_pin_b_low, profile_pin_a_high, profile_pin_a_low};
			pin_s2_r <= pin_s1_r;
			pin_s3_r <= pin_s2_r;
		end
	end

	assign lvl_nxt = (pin_s2_r & pin_s3_r) | (lvl_r & (pin_s2_r | pin_s3_r));
	assign rise    = lvl_nxt & ~lvl_r;

	always_ff @(posedge clock)
	begin
		if (rst)
			lvl_r <= 4'h0;
		else
			lvl_r <= lvl_nxt;
	end

	always_comb
	begin
		cnt_nxt = cnt_r;
		if (is_edge_mode(mode_r) && rise[mode_r[1:0]])
		begin
			if (cnt_r >= chan_r)
				cnt_nxt = 4'h0;
			else
				cnt_nxt = 4'(cnt_r + 4'h1);
		end
	end

	always_ff @(posedge clock)
	begin
		if (rst)
			cnt_r <= 4'h0;
		else
			cnt_r <= cnt_nxt;
	end

	always_comb
	begin
		profile_nxt = chan_r;
		case (mode_r)
			ddc_sel_pkg::MODE_REG:
				profile_nxt = chan_r;
			ddc_sel_pkg::MODE_B0_A0:
				profile_nxt = {2'b00, lvl_r[ddc_sel_pkg::PIN_B_LOW], lvl_r[ddc_sel_pkg::PIN_A_LOW]};
			ddc_sel_pkg::MODE_B1_A1:
				profile_nxt = {2'b00, lvl_r[ddc_sel_pkg::PIN_B_HIGH], lvl_r[ddc_sel_pkg::PIN_A_HIGH]};
			ddc_sel_pkg::MODE_A1_A0:
				profile_nxt = {2'b00, lvl_r[ddc_sel_pkg::PIN_A_HIGH], lvl_r[ddc_sel_pkg::PIN_A_LOW]};
			ddc_sel_pkg::MODE_B1_B0:
				profile_nxt = {2'b00, lvl_r[ddc_sel_pkg::PIN_B_HIGH], lvl_r[ddc_sel_pkg::PIN_B_LOW]};
			ddc_sel_pkg::MODE_INTERLV:
				profile_nxt = {lvl_r[ddc_sel_pkg::PIN_B_HIGH], lvl_r[ddc_sel_pkg::PIN_A_HIGH],
					lvl_r[ddc_sel_pkg::PIN_B_LOW], lvl_r[ddc_sel_pkg::PIN_A_LOW]};
			ddc_sel_pkg::MODE_GROUPED:
				profile_nxt = {lvl_r[ddc_sel_pkg::PIN_B_HIGH], lvl_r[ddc_sel_pkg::PIN_B_LOW],
					lvl_r[ddc_sel_pkg::PIN_A_HIGH], lvl_r[ddc_sel_pkg::PIN_A_LOW]};
			ddc_sel_pkg::MODE_EDGE_A0,
			ddc_sel_pkg::MODE_EDGE_A1,
			ddc_sel_pkg::MODE_EDGE_B0,
			ddc_sel_pkg::MODE_EDGE_B1:
				profile_nxt = cnt_r;
			default:
				profile_nxt = chan_r;
		endcase
	end

	always_ff @(posedge clock)
	begin
		if (rst)
			profile_r <= 4'h0;
		else
			profile_r <= profile_nxt;
	end

	assign active_profile = profile_r;

	sequence seq_wr_mixer;
		wb_cyc && wb_stb && wb_we && wb_ack && wb_sel[0] && idx == ddc_sel_pkg::MIXER_SEL_IDX;
	endsequence

	sequence seq_wr_ctrl;
		wb_cyc && wb_stb && wb_we && wb_ack && wb_sel[0] && idx == ddc_sel_pkg::NCO_CTRL_IDX;
	endsequence

	chk_iq_route: assert property (seq_wr_mixer ##1 1'b1 |=>
		i_from_b == $past(wb_dat_w[0], 2) && q_from_b == $past(wb_dat_w[2], 2))
		else $error("mixer input select did not reach the outputs");

	chk_reset_vals: assert property ($past(rst) |-> mode_r == 4'h0 && chan_r == 4'h0 && i_sel_r && q_sel_r)
		else $error("control fields wrong after reset");

	chk_ctrl_write: assert property (seq_wr_ctrl |=> {mode_r, chan_r} == $past(wb_dat_w[7:0]))
		else $error("nco control write not stored");

	chk_reg_profile: assert property (mode_r == 4'h0 && $stable(mode_r) |=>
		active_profile == $past(chan_r))
		else $error("register profile not applied");

	chk_pins_b0a0: assert property (mode_r == 4'h1 |=> active_profile == {2'b00, $past(lvl_r[2]), $past(lvl_r[0])})
		else $error("mode 1 profile wrong");

	chk_pins_b1a1: assert property (mode_r == 4'h2 |=> active_profile == {2'b00, $past(lvl_r[3]), $past(lvl_r[1])})
		else $error("mode 2 profile wrong");

	chk_pins_a1a0: assert property (mode_r == 4'h3 |=> active_profile == {2'b00, $past(lvl_r[1]), $past(lvl_r[0])})
		else $error("mode 3 profile wrong");

	chk_pins_b1b0: assert property (mode_r == 4'h4 |=> active_profile == {2'b00, $past(lvl_r[3]), $past(lvl_r[2])})
		else $error("mode 4 profile wrong");

	chk_pins_interlv: assert property (mode_r == 4'h5 |=>
		active_profile == $past({lvl_r[3], lvl_r[1], lvl_r[2], lvl_r[0]}))
		else $error("mode 5 profile wrong");

	chk_pins_grouped: assert property (mode_r == 4'h6 |=> active_profile == $past(lvl_r))
		else $error("mode 6 profile wrong");

	chk_step_a0: assert property (mode_r == 4'h8 && rise[0] && cnt_r < chan_r |=> cnt_r == $past(cnt_r) + 4'h1)
		else $error("counter missed pin a low edge");

	chk_step_a1: assert property (mode_r == 4'h9 && rise[1] && cnt_r < chan_r |=> cnt_r == $past(cnt_r) + 4'h1)
		else $error("counter missed pin a high edge");

	chk_step_b0: assert property (mode_r == 4'hA && rise[2] && cnt_r < chan_r |=> cnt_r == $past(cnt_r) + 4'h1)
		else $error("counter missed pin b low edge");

	chk_step_b1: assert property (mode_r == 4'hB && rise[3] && cnt_r < chan_r |=> cnt_r == $past(cnt_r) + 4'h1)
		else $error("counter missed pin b high edge");

	chk_cnt_wrap: assert property (is_edge_mode(mode_r) && rise[mode_r[1:0]] && cnt_r >= chan_r |=>
		cnt_r == 4'h0)
		else $error("counter did not wrap");

	chk_edge_profile: assert property (is_edge_mode(mode_r) |=> active_profile == $past(cnt_r))
		else $error("counter not driving the profile");

	chk_pin_rise: assert property ($rose(lvl_r[0]) |-> $past(pin_s2_r[0]) && $past(pin_s3_r[0]))
		else $error("pin level taken before stages agreed");

	chk_ack_once: assert property (wb_ack |=> !wb_ack)
		else $error("ack held longer than one cycle");

	// undefined modes fall back to the channel field
	chk_undef_profile: assert property (!is_edge_mode(mode_r) && mode_r > 4'h6 |=>
		active_profile == $past(chan_r))
		else $error("undefined mode did not use the channel field");

	chk_cnt_hold: assert property (!is_edge_mode(mode_r) |=> cnt_r == $past(cnt_r))
		else $error("counter moved outside the edge modes");

	chk_masked_write: assert property (wb_cyc && wb_stb && wb_we && wb_ack && !wb_sel[0] |=>
		$stable({mode_r, chan_r}) && $stable({i_sel_r, q_sel_r}))
		else $error("write with lane 0 disabled changed a register");

	chk_read_data: assert property (wb_cyc && wb_stb && wb_ack && !wb_we && idx == ddc_sel_pkg::NCO_CTRL_IDX |->
		wb_dat_r == {24'h000000, mode_r, chan_r})
		else $error("nco control read data wrong");

endmodule

/* tb/pin_host.sv */
// host side model that drives the four profile select pins
// assumes the bench hands it a level vector ordered a_low, a_high, b_low, b_high
`timescale 1ns/1ps
module pin_host
(
	input  wire logic       clock,
	input  wire logic [3:0] level,
	output logic            a_low,
	output logic            a_high,
	output logic            b_low,
	output logic            b_high
);
	// pins move only just after a clock edge, as the outside logic does
	always_ff @(posedge clock)
	begin
		{b_high, b_low, a_high, a_low} <= level;
	end
endmodule

/* tb/ddc_nco_channel_select_tb.sv */
// self-checking bench for mixer routing and nco profile selection
// assumes a classic wishbone slave and profile pins synchronised inside the block
`timescale 1ns/1ps
module ddc_nco_channel_select_tb;
	logic        clock;
	logic        rst;
	logic        wb_cyc;
	logic        wb_stb;
	logic        wb_we;
	logic [11:0] wb_adr;
	logic [3:0]  wb_sel;
	logic [31:0] wb_dat_w;
	logic [31:0] wb_dat_r;
	logic        wb_ack;
	logic        profile_pin_a_low;
	logic        profile_pin_a_high;
	logic        profile_pin_b_low;
	logic        profile_pin_b_high;
	logic        i_from_b;
	logic        q_from_b;
	logic [3:0]  active_profile;
	logic [3:0]  level;
	logic [7:0]  rd;
	int          n_errors;
	int          n_checks;
	int          cnt;

	ddc_nco_channel_select DUT
	(
		.clock,
		.rst,
		.wb_cyc,
		.wb_stb,
		.wb_we,
		.wb_adr,
		.wb_sel,
		.wb_dat_w,
		.wb_dat_r,
		.wb_ack,
		.profile_pin_a_low,
		.profile_pin_a_high,
		.profile_pin_b_low,
		.profile_pin_b_high,
		.i_from_b,
		.q_from_b,
		.active_profile
	);

	pin_host host
	(
		.clock  (clock),
		.level  (level),
		.a_low  (profile_pin_a_low),
		.a_high (profile_pin_a_high),
		.b_low  (profile_pin_b_low),
		.b_high (profile_pin_b_high)
	);

	initial
	begin
		clock = 1'b0;
		forever #2.5 clock = ~clock;
	end

	task automatic test_done();
		$display("checks %0d errors %0d", n_checks, n_errors);
		if (n_errors == 0 && n_checks > 0)
			$display("ALL CHECKS OK");
		else
			$display("CHECKS NOT OK");
		$finish;
	endtask

	task automatic chk(input string what, input logic [7:0] exp, input logic [7:0] got);
		n_checks++;
		if (got !== exp)
		begin
			n_errors++;
			$display("FAIL %s expected %h seen %h", what, exp, got);
		end
	endtask

	// one classic cycle; the request stands until the edge that samples ack, which also takes read data
	task automatic wb_xfer(input logic we, input logic [11:0] adr, input logic [3:0] sel,
		input logic [7:0] dat);
		int n;
		n = 0;
		@(posedge clock);
		wb_cyc   <= 1'b1;
		wb_stb   <= 1'b1;
		wb_we    <= we;
		wb_adr   <= adr;
		wb_sel   <= sel;
		wb_dat_w <= {24'h000000, dat};
		@(posedge clock);
		while (wb_ack !== 1'b1 && n < 20)
		begin
			@(posedge clock);
			n++;
		end
		rd = wb_dat_r[7:0];
		wb_cyc <= 1'b0;
		wb_stb <= 1'b0;
		if (n >= 20)
		begin
			n_errors++;
			test_done();
		end
	endtask

	task automatic settle(input int n);
		repeat (n) @(posedge clock);
		@(negedge clock);
	endtask

	function automatic logic [7:0] exp_lvl(input int m, input logic [3:0] p);
		case (m)
			1: return {6'h00, p[2], p[0]};
			2: return {6'h00, p[3], p[1]};
			3: return {6'h00, p[1], p[0]};
			4: return {6'h00, p[3], p[2]};
			5: return {4'h0, p[3], p[1], p[2], p[0]};
			default: return {4'h0, p[3], p[2], p[1], p[0]};
		endcase
	endfunction

	initial
	begin
		rst = 1'b1;
		wb_cyc = 1'b0;
		wb_stb = 1'b0;
		wb_we = 1'b0;
		wb_adr = 12'h000;
		wb_sel = 4'h0;
		wb_dat_w = 32'h00000000;
		level = 4'h0;
		n_errors = 0;
		n_checks = 0;
		cnt = 0;
		repeat (6) @(posedge clock);
		rst <= 1'b0;
		settle(1);
		chk("i_from_b", 8'h01, {7'h00, i_from_b});
		chk("q_from_b", 8'h01, {7'h00, q_from_b});
		chk("reset profile", 8'h00, {4'h0, active_profile});
		chk("wb_ack idle", 8'h00, {7'h00, wb_ack});
		wb_xfer(1'b0, 12'hDC4, 4'hF, 8'h00);
		chk("mixer select", 8'h05, rd);
		wb_xfer(1'b0, 12'hDD0, 4'hF, 8'h00);
		chk("nco control", 8'h00, rd);
		wb_xfer(1'b1, 12'hDC4, 4'hF, 8'h04);
		settle(3);
		chk("i and q", 8'h02, {6'h00, q_from_b, i_from_b});
		wb_xfer(1'b1, 12'hDC4, 4'hF, 8'h01);
		settle(3);
		chk("i and q", 8'h01, {6'h00, q_from_b, i_from_b});
		for (int c = 0; c < 16; c++)
		begin
			wb_xfer(1'b1, 12'hDD0, 4'hF, 8'(c));
			settle(3);
			chk("register profile", 8'(c), {4'h0, active_profile});
			wb_xfer(1'b0, 12'hDD0, 4'hF, 8'h00);
			chk("nco control", 8'(c), rd);
		end
		// write with lane 0 disabled must leave the control untouched
		wb_xfer(1'b1, 12'hDD0, 4'hE, 8'h37);
		wb_xfer(1'b0, 12'hDD0, 4'hF, 8'h00);
		chk("masked write", 8'h0F, rd);
		wb_xfer(1'b0, 12'h000, 4'hF, 8'h00);
		chk("unmapped read", 8'h00, rd);
		for (int m = 1; m < 7; m++)
		begin
			wb_xfer(1'b1, 12'hDD0, 4'hF, 8'(m * 16));
			for (int p = 0; p < 16; p++)
			begin
				@(posedge clock);
				level <= 4'(p);
				settle(8);
				chk("pin profile", exp_lvl(m, 4'(p)), {4'h0, active_profile});
			end
		end
		@(posedge clock);
		level <= 4'h0;
		settle(8);
		for (int m = 8; m < 12; m++)
		begin
			wb_xfer(1'b1, 12'hDD0, 4'hF, 8'(m * 16 + m - 7));
			for (int k = 0; k < 5; k++)
			begin
				@(posedge clock);
				level <= 4'(1 << (m - 8));
				repeat (6) @(posedge clock);
				level <= 4'h0;
				settle(6);
				cnt = (cnt >= m - 7) ? 0 : cnt + 1;
				chk("edge count", 8'(cnt), {4'h0, active_profile});
				wb_xfer(1'b0, 12'hFC0, 4'hF, 8'h00);
				chk("counter status", {4'(cnt), 4'(cnt)}, rd);
			end
		end
		wb_xfer(1'b1, 12'hDD0, 4'hF, 8'h75);
		settle(3);
		chk("undefined mode", 8'h05, {4'h0, active_profile});
		// reset in mid-run with mode, channel, q select and counter away from their reset values
		@(posedge clock);
		rst <= 1'b1;
		repeat (2) @(posedge clock);
		rst <= 1'b0;
		settle(1);
		chk("reset profile", 8'h00, {4'h0, active_profile});
		chk("i and q", 8'h03, {6'h00, q_from_b, i_from_b});
		wb_xfer(1'b0, 12'hDD0, 4'hF, 8'h00);
		chk("nco control", 8'h00, rd);
		wb_xfer(1'b0, 12'hDC4, 4'hF, 8'h00);
		chk("mixer select", 8'h05, rd);
		wb_xfer(1'b0, 12'hFC0, 4'hF, 8'h00);
		chk("counter status", 8'h00, rd);
		test_done();
	end
endmodule
